// ===== opw_pkg.sv
// Overview of operation
// - host opens each row with attribute, skip-line
// - first location holds first row skip-line
// - byte after restart is attribute, not character
// - host ends non-final rows with row-end
// - location after row-end is skip-line count
// - host ends window with window-end, never after row-end
// - frame: slave, addr low, addr high, attribute, data
// - data stored from start address, incrementing
// - latest attribute tags following codes
// - skip-line value gives blank pixel lines
// - skip-line then row-end gives transparent break
// - entry zero black transparent per control bit
// - entries nine and ten black stay opaque
// - first eight entries black transparent when bit zero
// - row-end is code one in bits 11..4
// - window-end is code zero, ends row and window
package opw_pkg;
  localparam logic [7:0]  OPW_SLAVE_ADDR    = 8'hBA;
  localparam logic [15:0] OPW_PAGE_BASE     = 16'h8000;
  localparam int          OPW_PAGE_DEPTH    = 512;
  localparam int          OPW_ADDR_W        = 9;
  localparam logic [7:0]  OPW_ROW_END_CODE  = 8'h01;
  localparam logic [7:0]  OPW_WIN_END_CODE  = 8'h00;
  localparam logic [3:0]  OPW_ATTR_TRANSP_LAST = 4'h7;
  localparam logic [3:0]  OPW_RESET_ATTR    = 4'h0;
  localparam logic [8:0]  OPW_BLACK_COLOR   = 9'h000;
  typedef enum logic [1:0] {OPW_CODE_SKIP, OPW_CODE_CHAR, OPW_CODE_ROW_END, OPW_CODE_WIN_END} opw_kind_t;
  typedef enum {OPW_ST_IDLE, OPW_ST_SLAVE, OPW_ST_ADDR_LO, OPW_ST_ADDR_HI, OPW_ST_ATTR, OPW_ST_DATA} opw_state_t;
endpackage

// ===== opw_link_if.sv
`timescale 1ns/10ps
// byte stream of one write transaction, host to device
interface opw_link_if;
  logic       start;
  logic       stop;
  logic       byte_valid;
  logic [7:0] byte_data;
  modport host   (output start, output stop, output byte_valid, output byte_data);
  modport device (input start, input stop, input byte_valid, input byte_data);
endinterface

// ===== opw_host.sv
`timescale 1ns/10ps
module opw_host (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // link
  opw_link_if.host        link,
  // user request: one frame
  input  wire logic       req_valid,
  input  wire logic [15:0] req_addr,
  input  wire logic [3:0] req_attr,
  input  wire logic [7:0] req_data,
  input  wire logic       req_last,
  output logic            req_ready,
  output logic            busy
);
  import opw_pkg::*;

  opw_state_t st_q;
  logic       start_q, stop_q, bv_q, rdy_q;
  logic       last_q, busy_q;
  logic [7:0] bd_q;

  assign link.start      = start_q;
  assign link.stop       = stop_q;
  assign link.byte_valid = bv_q;
  assign link.byte_data  = bd_q;
  assign req_ready       = rdy_q;
  assign busy            = busy_q;

  // frame sequencer; the user supplies attribute and skip-line first per row
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= OPW_ST_IDLE; start_q <= 1'b0; stop_q <= 1'b0;
      bv_q <= 1'b0; bd_q <= 8'h00; rdy_q <= 1'b0;
      last_q <= 1'b0; busy_q <= 1'b0;
    end
    else if (ce)
    begin
      start_q <= 1'b0; stop_q <= 1'b0; bv_q <= 1'b0; rdy_q <= 1'b0;
      busy_q <= (st_q != OPW_ST_IDLE);
      case (st_q)
        OPW_ST_IDLE: if (req_valid)
        begin
          start_q <= 1'b1; st_q <= OPW_ST_SLAVE;
        end
        OPW_ST_SLAVE:
        begin
          bv_q <= 1'b1; bd_q <= OPW_SLAVE_ADDR; st_q <= OPW_ST_ADDR_LO;
        end
        OPW_ST_ADDR_LO:
        begin
          bv_q <= 1'b1; bd_q <= req_addr[7:0]; st_q <= OPW_ST_ADDR_HI;
        end
        OPW_ST_ADDR_HI:
        begin
          bv_q <= 1'b1; bd_q <= req_addr[15:8]; st_q <= OPW_ST_ATTR;
        end
        OPW_ST_ATTR:
        begin
          bv_q <= 1'b1; bd_q <= {4'h0, req_attr}; st_q <= OPW_ST_DATA;
        end
        // stop follows the last byte one cycle later, so the byte is not lost
        default: if (last_q)
        begin
          stop_q <= 1'b1; last_q <= 1'b0; st_q <= OPW_ST_IDLE;
        end
        else if (req_valid && !rdy_q)
        begin
          bv_q <= 1'b1; bd_q <= req_data; rdy_q <= 1'b1;
          last_q <= req_last;
        end
      endcase
    end
  end
endmodule

// ===== opw_device.sv
`timescale 1ns/10ps
module opw_device (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // link
  opw_link_if.device      link,
  // frame control
  input  wire logic       transp_disable,
  // read port for the display side
  input  wire logic [8:0] rd_addr,
  output logic [11:0]     rd_word,
  output opw_pkg::opw_kind_t rd_kind,
  output logic [3:0]      rd_skip_lines,
  output logic            rd_transp_black,
  output logic            rd_row_break,
  // write strobe
  output logic            wr_pulse,
  output logic [8:0]      wr_addr
);
  import opw_pkg::*;

  // synchronise the link inputs
  logic [1:0] s_start, s_stop, s_bv;
  logic [7:0] bd_s1, bd_s2;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_start <= 2'b00; s_stop <= 2'b00; s_bv <= 2'b00; bd_s1 <= 8'h00; bd_s2 <= 8'h00;
    end
    else if (ce)
    begin
      s_start <= {s_start[0], link.start};
      s_stop  <= {s_stop[0], link.stop};
      s_bv    <= {s_bv[0], link.byte_valid};
      bd_s1   <= link.byte_data;
      bd_s2   <= bd_s1;
    end
  end

  logic [11:0] mem [OPW_PAGE_DEPTH];
  opw_state_t  st_q;
  logic [8:0]  addr_q, wa_q;
  logic [3:0]  attr_q;
  logic        wr_q;
  logic [11:0] rw_q;
  logic        br_q;

  // interpret a stored word given the previous one
  function automatic opw_kind_t opw_classify(input logic [11:0] w, input logic prev_re, input logic first);
    if (first || prev_re)
      opw_classify = OPW_CODE_SKIP;
    else if (w[11:4] == OPW_ROW_END_CODE)
      opw_classify = OPW_CODE_ROW_END;
    else if (w[11:4] == OPW_WIN_END_CODE)
      opw_classify = OPW_CODE_WIN_END;
    else
      opw_classify = OPW_CODE_CHAR;
  endfunction

  wire first_loc = (rd_addr == 9'h000);
  wire [8:0] prev_addr = rd_addr - 9'h001;
  wire prev_is_re  = !first_loc && (mem[prev_addr][11:4] == OPW_ROW_END_CODE);
  wire opw_kind_t kind_w = opw_classify(mem[rd_addr], prev_is_re, first_loc);
  wire [3:0] att_w = mem[rd_addr][3:0];
  // transparency of black in the addressed entry
  wire transp_w = (att_w <= OPW_ATTR_TRANSP_LAST) && !transp_disable;
  wire nxt_re = (mem[rd_addr + 9'h001][11:4] == OPW_ROW_END_CODE);

  // transaction parser and page memory writes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= OPW_ST_IDLE; addr_q <= 9'h000; attr_q <= OPW_RESET_ATTR;
      wr_q <= 1'b0; wa_q <= 9'h000;
    end
    else if (ce)
    begin
      wr_q <= 1'b0;
      if (s_start[1])
      begin
        st_q <= OPW_ST_SLAVE; addr_q <= 9'h000; attr_q <= OPW_RESET_ATTR;
      end
      else if (s_stop[1])
        st_q <= OPW_ST_IDLE;
      else if (s_bv[1])
      begin
        case (st_q)
          OPW_ST_SLAVE:   st_q <= (bd_s2 == OPW_SLAVE_ADDR) ? OPW_ST_ADDR_LO : OPW_ST_IDLE;
          OPW_ST_ADDR_LO:
          begin
            addr_q[7:0] <= bd_s2; st_q <= OPW_ST_ADDR_HI;
          end
          OPW_ST_ADDR_HI:
          begin
            addr_q[8] <= bd_s2[0];
            st_q <= (bd_s2[7:1] == OPW_PAGE_BASE[15:9]) ? OPW_ST_ATTR : OPW_ST_IDLE;
          end
          OPW_ST_ATTR:
          begin
            attr_q <= bd_s2[3:0]; st_q <= OPW_ST_DATA;
          end
          OPW_ST_DATA:
          begin
            wr_q <= 1'b1; wa_q <= addr_q; addr_q <= addr_q + 9'h001;
          end
          default: st_q <= OPW_ST_IDLE;
        endcase
      end
    end
  end

  // page memory store: code in 11..4, attribute in 3..0
  always_ff @(posedge clk_sys)
  begin
    if (ce && s_bv[1] && st_q == OPW_ST_DATA && !s_start[1] && !s_stop[1])
      mem[addr_q] <= {bd_s2, attr_q};
  end

  // registered read decode
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rw_q <= 12'h000; br_q <= 1'b0;
      rd_kind <= OPW_CODE_SKIP; rd_skip_lines <= 4'h0; rd_transp_black <= 1'b0;
    end
    else if (ce)
    begin
      rw_q <= mem[rd_addr];
      rd_kind <= kind_w;
      rd_skip_lines <= (kind_w == OPW_CODE_SKIP) ? mem[rd_addr][7:4] : 4'h0;
      rd_transp_black <= transp_w;
      br_q <= (kind_w == OPW_CODE_SKIP) && nxt_re;
    end
  end

  assign rd_word      = rw_q;
  assign rd_row_break = br_q;
  assign wr_pulse     = wr_q;
  assign wr_addr      = wa_q;
endmodule

// ===== opw_link_assertions.sv
`timescale 1ns/10ps
module opw_link_assertions (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // link
  input wire logic       start,
  input wire logic       stop,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data
);
  import opw_pkg::*;
  logic [9:0] cnt_q;
  logic       in_frame_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // bytes seen since the last start
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      cnt_q      <= 10'h000;
      in_frame_q <= 1'b0;
    end
    else
    begin
      cnt_q      <= start ? 10'h000 : cnt_q + 10'(byte_valid);
      in_frame_q <= start | (in_frame_q & ~stop);
    end
  AST_SLAVE_FIRST: assert property (start |=> byte_valid && byte_data == OPW_SLAVE_ADDR)
    else $error("slave byte missing after start");
  AST_START_CLEAN: assert property (start |-> !byte_valid && !stop)
    else $error("start overlaps byte or stop");
  AST_START_PULSE: assert property (start |=> !start)
    else $error("start longer than one cycle");
  AST_STOP_AFTER_DATA: assert property (stop |-> in_frame_q && cnt_q >= 10'h005)
    else $error("stop before first data byte");
  AST_STOP_PULSE: assert property ($rose(stop) |=> !stop)
    else $error("stop longer than one cycle");
  AST_FRAME_BOUNDED: assert property (start |-> ##[5:1000] stop)
    else $error("frame never closed");
  AST_NO_RESTART: assert property (in_frame_q && !stop |-> !start)
    else $error("start inside open frame");
  AST_IDLE_QUIET: assert property (!in_frame_q && !start |-> !byte_valid && !stop)
    else $error("link active outside frame");
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import opw_pkg::*;
  typedef struct {logic [8:0] a; logic [11:0] w; opw_kind_t k;} opw_row_t;
  logic        clk_sys, rst, ce, req_valid, req_last, req_ready, busy, transp_disable;
  logic        rd_transp_black, rd_row_break;
  logic [15:0] req_addr;
  logic [3:0]  req_attr, rd_skip_lines;
  logic [7:0]  req_data;
  logic [8:0]  rd_addr;
  logic [11:0] rd_word;
  opw_kind_t   rd_kind;
  int          fails, total_checks, wr_count;
  logic        wr_pulse;
  logic [8:0]  wr_addr;
  // expected page contents: address, code and attribute, kind
  opw_row_t rows [9] = '{'{9'h000, 12'h020, OPW_CODE_SKIP}, '{9'h001, 12'h410, OPW_CODE_CHAR},
    '{9'h002, 12'h010, OPW_CODE_ROW_END}, '{9'h003, 12'h039, OPW_CODE_SKIP},
    '{9'h004, 12'h019, OPW_CODE_ROW_END}, '{9'h005, 12'h00A, OPW_CODE_SKIP},
    '{9'h006, 12'h05A, OPW_CODE_CHAR}, '{9'h007, 12'h062, OPW_CODE_CHAR},
    '{9'h008, 12'h002, OPW_CODE_WIN_END}};
  opw_link_if link ();
  opw_host i_opw_host (.clk_sys(clk_sys), .rst(rst), .ce(ce), .link(link), .req_valid(req_valid),
    .req_addr(req_addr), .req_attr(req_attr), .req_data(req_data), .req_last(req_last),
    .req_ready(req_ready), .busy(busy));
  opw_device i_opw_device (.clk_sys(clk_sys), .rst(rst), .ce(ce), .link(link),
    .transp_disable(transp_disable), .rd_addr(rd_addr), .rd_word(rd_word), .rd_kind(rd_kind),
    .rd_skip_lines(rd_skip_lines), .rd_transp_black(rd_transp_black), .rd_row_break(rd_row_break),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr));
  // count page memory writes
  always @(posedge clk_sys)
    if (wr_pulse)
      wr_count <= wr_count + 1;
  opw_link_assertions i_opw_link_assertions (.clk_sys(clk_sys), .rst(rst), .start(link.start),
    .stop(link.stop), .byte_valid(link.byte_valid), .byte_data(link.byte_data));
  // free-running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(string n, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bounded wait on a settled level
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (s !== v)
    begin
      fails++;
      print_verdict;
    end
  endtask
  // one frame: start address, attribute, data bytes
  task send(logic [15:0] a, logic [3:0] t, logic [7:0] d[$]);
    foreach (d[i])
    begin
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_addr  <= a;
      req_attr  <= t;
      req_data  <= d[i];
      req_last  <= (i == d.size() - 1);
      @(negedge clk_sys);
      wait_for(req_ready, 1'b1);
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    wait_for(busy, 1'b0);
    repeat (8) @(posedge clk_sys);
  endtask
  task rd(logic [8:0] a);
    @(posedge clk_sys);
    rd_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // main sequence
  initial
  begin
    {rst, ce, req_valid, req_last, req_addr, req_attr, req_data, rd_addr, transp_disable} = '0;
    rst = 1'b1;
    ce = 1'b1;
    fails = 0;
    total_checks = 0;
    wr_count = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    send(16'h8000, 4'h0, {8'h02, 8'h41, 8'h01});
    send(16'h8003, 4'h9, {8'h03, 8'h01});
    send(16'h8005, 4'hA, {8'h00, 8'h05});
    send(16'h8007, 4'h2, {8'h06, 8'h00});
    send(16'h8200, 4'h0, {8'h77});
    chk("writes", wr_count, 16'h0009);
    chk("wr_last", wr_addr, 16'h0008);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("word", rd_word, rows[i].w);
      chk("kind", rd_kind, rows[i].k);
    end
    rd(9'h000);
    chk("skip", rd_skip_lines, 4'h2);
    chk("transp", rd_transp_black, 1'b1);
    chk("break", rd_row_break, 1'b0);
    rd(9'h003);
    chk("skip", rd_skip_lines, 4'h3);
    chk("transp", rd_transp_black, 1'b0);
    chk("break", rd_row_break, 1'b1);
    @(posedge clk_sys);
    transp_disable <= 1'b1;
    rd(9'h000);
    chk("transp", rd_transp_black, 1'b0);
    // reset in mid-run: outputs clear, page memory kept
    @(posedge clk_sys);
    rst <= 1'b1;
    @(negedge clk_sys);
    chk("rst_word", rd_word, 16'h0000);
    chk("rst_busy", busy, 16'h0000);
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(9'h003);
    chk("post_word", rd_word, 16'h0039);
    print_verdict;
  end
endmodule
